// >>> pcm_consts.vh
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH

// control bytes
`define PCM_CMD_READ_MAIN   8'h30
`define PCM_CMD_UPD_MAIN    8'h38
`define PCM_CMD_READ_PROT   8'h34
`define PCM_CMD_WRITE_PROT  8'h3C
`define PCM_CMD_READ_SEC    8'h31
`define PCM_CMD_UPD_SEC     8'h39
`define PCM_CMD_COMPARE     8'h33

// sizes
`define PCM_MAIN_BYTES      256
`define PCM_PROT_BITS       32
`define PCM_SEC_BYTES       4
`define PCM_ATR_BITS        6'h20
`define PCM_CMD_BITS        5'h18
`define PCM_MAIN_END_PTR    12'h800
`define PCM_PROT_END_PTR    12'h020
`define PCM_SEC_END_PTR     12'h020
`define PCM_ERASED_BYTE     8'hFF
`define PCM_RETRY_LSB       0
`define PCM_RETRY_MSB       2

// nonvolatile step time
`define PCM_PROG_TIME_US    2500
`define PCM_CLK_MHZ         20
// 2500 us at 20 MHz, sized to the programming timer
`define PCM_PROG_CYCLES     18'h0_C350

// avalon register map, byte addresses
`define PCM_REG_CTRL        4'h0
`define PCM_REG_STATUS      4'h4
`define PCM_CTRL_SECURE_BIT 0
`define PCM_CTRL_RESET      32'h0000_0001
`define PCM_SECURE_RESET    1'b1

// power-up contents of the security store
`define PCM_RETRY_INIT      8'h07
`define PCM_CODE_INIT       24'hFF_FFFF

`endif

// >>> pcm_card_memory.v
// Summary of operation
// - 256 bytes; erase sets all bits one
// - write only clears bits: old AND new
// - skip unneeded erase or write step
// - each erase/write step lasts 2.5 ms
// - bytes 0-31 have permanent protection bits
// - security store: retry counter, 3-byte code
// - secure variant read-only until code matches
// - exhausted retry counter blocks all comparisons
// - data line changes on falling clock, and on reset fall or break
// - reset fall with clock starts 32-bit answer
// - command: start, three bytes, clock, stop
// - detect start and stop while clock high
// - bytes lsb first: control, address, data
// - outgoing data, release one clock after last
// - processing holds line low until finished
// - reset high with clock low aborts, releases
// - decode 30, 38, 34, 3C commands
// - secure variant decodes 31, 39, 33
// - read main streams address N to 255
// - read protection: 32 bits, then release
// - protected update releases after clock two
// - protection bit set only on identical data
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcm_consts.vh"

module pcm_card_memory #(
  parameter [17:0] PROG_CYCLES = `PCM_PROG_CYCLES,
  parameter [23:0] CODE_INIT   = `PCM_CODE_INIT
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        cardClk,
  input  wire        cardRst,
  input  wire        cardIoIn,
  output wire        cardIoOut,
  output wire        cardIoOe,
  input  wire [3:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWritedata,
  output wire [31:0] avsReaddata,
  output wire        avsWaitrequest
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_RESET = 3'd1;
  localparam [2:0] ST_ATR   = 3'd2;
  localparam [2:0] ST_CMD   = 3'd3;
  localparam [2:0] ST_OUT   = 3'd4;
  localparam [2:0] ST_PROC  = 3'd5;

  localparam [1:0] SRC_MAIN = 2'd0;
  localparam [1:0] SRC_PROT = 2'd1;
  localparam [1:0] SRC_SEC  = 2'd2;

  localparam [2:0] PK_NONE = 3'd0;
  localparam [2:0] PK_MAIN = 3'd1;
  localparam [2:0] PK_PROT = 3'd2;
  localparam [2:0] PK_SEC  = 3'd3;
  localparam [2:0] PK_CMP  = 3'd4;

  // nonvolatile arrays keep their contents across srst
  reg [7:0]  mainMem [0:`PCM_MAIN_BYTES-1];
  reg [7:0]  secMem  [0:`PCM_SEC_BYTES-1];
  reg [31:0] protBits;
  integer    i;
  initial begin
    for (i = 0; i < `PCM_MAIN_BYTES; i = i + 1) begin
      mainMem[i] = `PCM_ERASED_BYTE;
    end
    secMem[0] = `PCM_RETRY_INIT;
    secMem[1] = CODE_INIT[7:0];
    secMem[2] = CODE_INIT[15:8];
    secMem[3] = CODE_INIT[23:16];
    protBits = 32'h0000_0000;
  end

  // nonzero steps needed to turn old into new: erase, then write
  function [1:0] progSteps;
    input [7:0] oldVal;
    input [7:0] newVal;
    reg         needErase;
    reg [7:0]   base;
    begin
      needErase = |(~oldVal & newVal);
      base      = needErase ? `PCM_ERASED_BYTE : oldVal;
      progSteps = {1'b0, needErase} + {1'b0, |(base & ~newVal)};
    end
  endfunction

  // pin synchronisers, the third stage only feeds edge detection
  reg cClk1_reg, cClk2_reg, cClk3_reg;
  reg cRst1_reg, cRst2_reg, cRst3_reg;
  reg cIo1_reg,  cIo2_reg,  cIo3_reg;
  always @(posedge mclk) begin
    cClk1_reg <= cardClk;
    cClk2_reg <= cClk1_reg;
    cClk3_reg <= cClk2_reg;
    cRst1_reg <= cardRst;
    cRst2_reg <= cRst1_reg;
    cRst3_reg <= cRst2_reg;
    cIo1_reg  <= cardIoIn;
    cIo2_reg  <= cIo1_reg;
    cIo3_reg  <= cIo2_reg;
  end

  wire clkRise = cClk2_reg & ~cClk3_reg;
  wire clkFall = ~cClk2_reg & cClk3_reg;
  wire rstRise = cRst2_reg & ~cRst3_reg;
  wire rstFall = ~cRst2_reg & cRst3_reg;
  wire startCond = ~cIo2_reg & cIo3_reg & cClk2_reg & cClk3_reg;
  wire stopCond  = cIo2_reg & ~cIo3_reg & cClk2_reg & cClk3_reg;

  reg [2:0]  state_reg;
  reg        oe_reg;
  reg        atrArm_reg;
  reg [5:0]  atrCnt_reg;
  reg [23:0] shift_reg;
  reg [4:0]  bitCnt_reg;
  reg [1:0]  src_reg;
  reg [11:0] ptr_reg;
  reg [11:0] endPtr_reg;
  reg [17:0] timer_reg;
  reg [1:0]  procFalls_reg;
  reg [2:0]  pendKind_reg;
  reg [7:0]  pendAddr_reg;
  reg [7:0]  pendVal_reg;
  reg        pendUnlock_reg;
  reg        unlocked_reg;
  reg [3:1]  cmpOk_reg;
  reg        secureEn_reg;

  wire [7:0] cmdByte  = shift_reg[7:0];
  wire [7:0] addrByte = shift_reg[15:8];
  wire [7:0] dataByte = shift_reg[23:16];
  wire [2:0] retryCnt = secMem[0][`PCM_RETRY_MSB:`PCM_RETRY_LSB];
  wire       writeOk  = ~secureEn_reg | unlocked_reg;
  wire       lowByte  = addrByte < `PCM_PROT_BITS;
  wire [7:0] mainOld  = mainMem[addrByte];
  wire [7:0] secOld   = secMem[addrByte[1:0]];
  wire       secAddrOk = addrByte < `PCM_SEC_BYTES;
  wire       cmpAll   = &cmpOk_reg;

  // outgoing bit for the current stream pointer
  reg outBit;
  always @* begin
    case (src_reg)
      SRC_MAIN: outBit = mainMem[ptr_reg[10:3]][ptr_reg[2:0]];
      SRC_PROT: outBit = protBits[ptr_reg[4:0]];
      SRC_SEC: begin
        // the code bytes stay hidden while the store is locked
        if (ptr_reg[4:3] != 2'd0 && !writeOk) begin
          outBit = 1'b0;
        end else begin
          outBit = secMem[ptr_reg[4:3]][ptr_reg[2:0]];
        end
      end
      default: outBit = 1'b1;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      state_reg      <= ST_IDLE;
      oe_reg         <= 1'b0;
      atrArm_reg     <= 1'b0;
      atrCnt_reg     <= 6'h00;
      shift_reg      <= 24'h00_0000;
      bitCnt_reg     <= 5'h00;
      src_reg        <= SRC_MAIN;
      ptr_reg        <= 12'h000;
      endPtr_reg     <= 12'h000;
      timer_reg      <= 18'h0_0000;
      procFalls_reg  <= 2'd0;
      pendKind_reg   <= PK_NONE;
      pendAddr_reg   <= 8'h00;
      pendVal_reg    <= 8'h00;
      pendUnlock_reg <= 1'b0;
      unlocked_reg   <= 1'b0;
      cmpOk_reg      <= 3'b000;
    end else if (rstRise || (cRst2_reg && state_reg != ST_RESET)) begin
      // break: abandon any pending change and let go of the line
      state_reg    <= ST_RESET;
      oe_reg       <= 1'b0;
      pendKind_reg <= PK_NONE;
      atrArm_reg   <= 1'b0;
    end else begin
      if (timer_reg != 18'h0_0000) begin
        timer_reg <= timer_reg - 18'h0_0001;
      end
      case (state_reg)
        ST_RESET: begin
          if (clkRise) begin
            atrArm_reg <= 1'b1;
          end
          if (rstFall) begin
            if (cClk2_reg && atrArm_reg) begin
              state_reg  <= ST_ATR;
              ptr_reg    <= 12'h000;
              atrCnt_reg <= 6'h00;
              oe_reg     <= ~mainMem[0][0];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ATR: begin
          if (clkFall) begin
            // first fall belongs to the reset pulse, bit 0 already out
            atrCnt_reg <= atrCnt_reg + 6'h01;
            if (atrCnt_reg == `PCM_ATR_BITS) begin
              oe_reg    <= 1'b0;
              state_reg <= ST_IDLE;
            end else if (atrCnt_reg != 6'h00) begin
              oe_reg <= ~mainMem[atrCnt_reg[4:3]][atrCnt_reg[2:0]];
            end
          end
        end
        ST_IDLE: begin
          if (startCond) begin
            state_reg  <= ST_CMD;
            bitCnt_reg <= 5'h00;
          end
        end
        ST_CMD: begin
          if (startCond) begin
            bitCnt_reg <= 5'h00;
          end else if (stopCond) begin
            state_reg     <= ST_IDLE;
            procFalls_reg <= 2'd0;
            pendKind_reg  <= PK_NONE;
            pendAddr_reg  <= addrByte;
            pendVal_reg   <= dataByte;
            pendUnlock_reg <= 1'b0;
            ptr_reg       <= 12'h000;
            // short frames are dropped
            if (bitCnt_reg == `PCM_CMD_BITS) begin
              case (cmdByte)
                `PCM_CMD_READ_MAIN: begin
                  state_reg  <= ST_OUT;
                  src_reg    <= SRC_MAIN;
                  ptr_reg    <= {1'b0, addrByte, 3'b000};
                  endPtr_reg <= `PCM_MAIN_END_PTR;
                end
                `PCM_CMD_READ_PROT: begin
                  state_reg  <= ST_OUT;
                  src_reg    <= SRC_PROT;
                  endPtr_reg <= `PCM_PROT_END_PTR;
                end
                `PCM_CMD_UPD_MAIN: begin
                  state_reg <= ST_PROC;
                  if (writeOk && !(lowByte && protBits[addrByte[4:0]])) begin
                    pendKind_reg <= PK_MAIN;
                    timer_reg <= PROG_CYCLES * progSteps(mainOld, dataByte);
                  end
                end
                `PCM_CMD_WRITE_PROT: begin
                  state_reg <= ST_PROC;
                  if (writeOk && lowByte && mainOld == dataByte
                      && !protBits[addrByte[4:0]]) begin
                    pendKind_reg <= PK_PROT;
                    timer_reg    <= PROG_CYCLES;
                  end
                end
                default: begin
                  if (secureEn_reg && cmdByte == `PCM_CMD_READ_SEC) begin
                    state_reg  <= ST_OUT;
                    src_reg    <= SRC_SEC;
                    endPtr_reg <= `PCM_SEC_END_PTR;
                  end else if (secureEn_reg && cmdByte == `PCM_CMD_UPD_SEC) begin
                    state_reg <= ST_PROC;
                    if (secAddrOk && (writeOk || (addrByte == 8'h00 && cmpAll))) begin
                      pendKind_reg   <= PK_SEC;
                      pendUnlock_reg <= addrByte == 8'h00 && cmpAll;
                      timer_reg <= PROG_CYCLES * progSteps(secOld, dataByte);
                    end else if (addrByte == 8'h00) begin
                      // while locked the counter can only lose bits
                      pendKind_reg <= PK_SEC;
                      pendVal_reg  <= secOld & dataByte;
                      timer_reg <= PROG_CYCLES * progSteps(secOld, secOld & dataByte);
                    end
                  end else if (secureEn_reg && cmdByte == `PCM_CMD_COMPARE) begin
                    state_reg <= ST_PROC;
                    if (retryCnt != 3'b000 && secAddrOk && addrByte != 8'h00) begin
                      pendKind_reg <= PK_CMP;
                    end
                  end
                  // anything else falls back to idle untouched
                end
              endcase
            end
          end else if (clkRise && bitCnt_reg != `PCM_CMD_BITS) begin
            shift_reg  <= {cIo2_reg, shift_reg[23:1]};
            bitCnt_reg <= bitCnt_reg + 5'h01;
          end
        end
        ST_OUT: begin
          // start and stop are not looked at here
          if (clkFall) begin
            if (ptr_reg != endPtr_reg) begin
              oe_reg  <= ~outBit;
              ptr_reg <= ptr_reg + 12'h001;
            end else begin
              oe_reg    <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_PROC: begin
          if (clkFall) begin
            if (procFalls_reg == 2'd0) begin
              oe_reg        <= 1'b1;
              procFalls_reg <= 2'd1;
            end else if (timer_reg == 18'h0_0000) begin
              oe_reg    <= 1'b0;
              state_reg <= ST_IDLE;
              case (pendKind_reg)
                PK_MAIN: mainMem[pendAddr_reg] <= pendVal_reg;
                PK_PROT: protBits[pendAddr_reg[4:0]] <= 1'b1;
                PK_SEC: begin
                  secMem[pendAddr_reg[1:0]] <= pendVal_reg;
                  if (pendUnlock_reg) begin
                    unlocked_reg <= 1'b1;
                  end
                end
                PK_CMP: cmpOk_reg[pendAddr_reg[1:0]] <=
                          pendVal_reg == secMem[pendAddr_reg[1:0]];
                default: begin
                end
              endcase
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // open drain: the pin only ever pulls low
  assign cardIoOut = 1'b0;
  assign cardIoOe  = oe_reg;

  // avalon slave, one wait state on every access
  reg        ack_reg;
  reg [31:0] rdata_reg;
  wire       req = avsRead | avsWrite;
  assign avsWaitrequest = req & ~ack_reg;
  assign avsReaddata    = rdata_reg;

  always @(posedge mclk) begin
    if (srst) begin
      ack_reg      <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      secureEn_reg <= `PCM_SECURE_RESET;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avsRead && !ack_reg) begin
        case (avsAddress)
          `PCM_REG_CTRL:   rdata_reg <= {31'h0000_0000, secureEn_reg};
          `PCM_REG_STATUS: rdata_reg <= {20'h0_0000, protBits[0], cmpOk_reg,
                            (timer_reg != 18'h0_0000), unlocked_reg,
                            retryCnt, state_reg};
          default:         rdata_reg <= 32'h0000_0000;
        endcase
      end
      if (avsWrite && ack_reg && avsAddress == `PCM_REG_CTRL) begin
        secureEn_reg <= avsWritedata[`PCM_CTRL_SECURE_BIT];
      end
    end
  end

endmodule
`default_nettype wire

// >>> pcm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_monitor #(
  parameter [17:0] PROG_CYCLES = 18'h0_0014,
  parameter [23:0] CODE_INIT   = 24'hFF_FFFF
) (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        cardClk,
  input wire logic        cardRst,
  input wire logic        cardIoIn,
  input wire logic        cardIoOut,
  input wire logic        cardIoOe,
  input wire logic [3:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [31:0] avsReaddata,
  input wire logic        avsWaitrequest
);
  // mclk cycles since the link clock last fell, saturating
  logic [3:0] sinceFall;
  logic       clkDly;
  initial sinceFall = 4'hF;
  always @(posedge mclk) begin
    clkDly <= cardClk;
    if (clkDly && !cardClk)
      sinceFall <= 4'h0;
    else if (sinceFall != 4'hF)
      sinceFall <= sinceFall + 4'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_out_low: assert property (cardIoOut == 1'b0)
    else $error("data output not held low");
  // transitions right after a link reset edge belong to break and answer-to-reset
  a_io_on_fall: assert property ($changed(cardIoOe) && !cardRst && !$past(cardRst, 6)
    |-> sinceFall <= 4'h5) else $error("data line moved away from a clock fall");
  a_break_release: assert property ((cardRst && !cardClk) [*6] |-> !cardIoOe)
    else $error("data line held during break");
  a_srst_idle: assert property ($fell(srst) |-> !cardIoOe)
    else $error("data line pulled after reset");
  a_wait_one: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("bus answer later than one cycle");
  a_wait_idle: assert property (!(avsRead || avsWrite) |-> !avsWaitrequest)
    else $error("waitrequest without request");
  a_unmapped_zero: assert property (avsRead && !avsWaitrequest && avsAddress != 4'h0
    && avsAddress != 4'h4 |-> avsReaddata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ctrl_bits: assert property (avsRead && !avsWaitrequest && avsAddress == 4'h0
    |-> avsReaddata[31:1] == 31'h0000_0000) else $error("control spare bits set");
endmodule
`default_nettype wire

// >>> pcm_reader_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_reader_model (
  input  wire logic mclk,
  input  wire logic cardIoOe,
  output var logic  cardClk,
  output var logic  cardRst,
  output wire logic cardIoIn
);
  logic hostLow;
  initial begin
    cardClk = 1'b0;
    cardRst = 1'b0;
    hostLow = 1'b0;
  end
  // open-drain line with pull-up
  assign cardIoIn = !(cardIoOe || hostLow);
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // the bit is taken just before the fall that replaces it
  task automatic pulse(output logic s);
    cardClk <= 1'b1;
    cyc(4);
    s = cardIoIn;
    cardClk <= 1'b0;
    cyc(4);
  endtask
  task automatic atr(output logic [31:0] bits);
    cardRst <= 1'b1;
    cyc(8);
    cardClk <= 1'b1;
    cyc(4);
    cardRst <= 1'b0;
    cyc(4);
    cardClk <= 1'b0;
    cyc(4);
    for (int i = 0; i < 32; i++) pulse(bits[i]);
  endtask
  // frame is data, address, control; sent from bit 0 up
  task automatic send(input logic [23:0] frame);
    cardClk <= 1'b1;
    cyc(2);
    hostLow <= 1'b1;
    cyc(2);
    cardClk <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      cyc(2);
      hostLow <= !frame[i];
      cyc(2);
      cardClk <= 1'b1;
      cyc(4);
      cardClk <= 1'b0;
    end
    cyc(2);
    hostLow <= 1'b1;
    cyc(2);
    cardClk <= 1'b1;
    cyc(2);
    hostLow <= 1'b0;
    cyc(2);
    cardClk <= 1'b0;
    cyc(4);
  endtask
  // keeps clocking until the device lets go of the line
  task automatic proc(output int n);
    logic s;
    n = 0;
    s = 1'b0;
    while (!s && n < 400) begin
      pulse(s);
      n++;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcm_consts.vh"
module tb_top;
  // pulses: link clocks until release, with the timer set to 20 mclk per step
  typedef struct packed {logic [7:0] addr, data, exp, pulses;} pcm_row_t;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [3:0]  avsAddress = 4'h0;
  logic [31:0] avsWritedata = 32'h0000_0000;
  wire         cardClk, cardRst, cardIoIn, cardIoOut, cardIoOe, avsWaitrequest;
  wire  [31:0] avsReaddata;
  int          mismatches = 0;
  int          cmpCount = 0;
  int          ticks = 0;
  pcm_row_t    rows [4] = '{'{8'hFE, 8'h5A, 8'h5A, 8'h04}, '{8'hFE, 8'hF0, 8'hF0, 8'h06},
                            '{8'hFE, 8'hFF, 8'hFF, 8'h04}, '{8'hFF, 8'h00, 8'h00, 8'h04}};
  logic [23:0] unlock [5] = '{24'h06_0039, 24'hFF_0133, 24'hFF_0233, 24'hFF_0333,
                              24'h07_0039};
  pcm_card_memory #(.PROG_CYCLES(18'h0_0014)) uut (.mclk(mclk), .srst(srst),
    .cardClk(cardClk), .cardRst(cardRst), .cardIoIn(cardIoIn), .cardIoOut(cardIoOut),
    .cardIoOe(cardIoOe), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest));
  pcm_reader_model u_host (.mclk(mclk), .cardIoOe(cardIoOe), .cardClk(cardClk),
    .cardRst(cardRst), .cardIoIn(cardIoIn));
  always #25 mclk = ~mclk;
  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    ticks++;
    if (ticks == 40000) begin
      mismatches++;
      wrapUp();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge mclk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic readOut(input logic [7:0] ctl, a, input int bits, output logic [31:0] q);
    logic s;
    q = 32'h0000_0000;
    u_host.send({8'h00, a, ctl});
    for (int i = 0; i < bits; i++) begin
      u_host.pulse(s);
      if (i < 32) q[i] = s;
    end
    u_host.cyc(4);
    check("release", {31'h0, cardIoOe}, 32'h0000_0000);
  endtask
  initial begin
    int n;
    logic [31:0] q;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    bus(1'b0, `PCM_REG_CTRL, 32'h0000_0000, q);
    check("ctrl", q, `PCM_CTRL_RESET);
    bus(1'b1, 4'h8, 32'hFFFF_FFFF, q);
    bus(1'b0, 4'h8, 32'h0000_0000, q);
    check("unmapped", q, 32'h0000_0000);
    bus(1'b1, `PCM_REG_CTRL, 32'h0000_0000, q);
    foreach (rows[i]) begin
      u_host.send({rows[i].data, rows[i].addr, `PCM_CMD_UPD_MAIN});
      u_host.proc(n);
      check("pulses", n, {24'h0, rows[i].pulses});
      readOut(`PCM_CMD_READ_MAIN, rows[i].addr, (256 - rows[i].addr) * 8, q);
      check("main", {24'h0, q[7:0]}, {24'h0, rows[i].exp});
    end
    u_host.send(24'h00_0000);
    u_host.proc(n);
    check("no-op", n, 1);
    u_host.send({8'h00, 8'h01, `PCM_CMD_WRITE_PROT});
    u_host.proc(n);
    readOut(`PCM_CMD_READ_PROT, 8'h00, 32, q);
    check("prot differ", q, 32'h0000_0000);
    u_host.send({8'hFF, 8'h01, `PCM_CMD_WRITE_PROT});
    u_host.proc(n);
    u_host.send({8'h00, 8'h01, `PCM_CMD_UPD_MAIN});
    u_host.proc(n);
    check("prot release", n, 2);
    readOut(`PCM_CMD_READ_PROT, 8'h00, 32, q);
    check("prot", q, 32'h0000_0002);
    u_host.send({8'hA5, 8'h00, `PCM_CMD_UPD_MAIN});
    u_host.proc(n);
    // reset in mid-processing drops the pending write to byte 2
    u_host.send({8'h00, 8'h02, `PCM_CMD_UPD_MAIN});
    u_host.atr(q);
    check("atr", q, 32'hFFFF_FFA5);
    u_host.cyc(4);
    check("atr end", {31'h0, cardIoOe}, 32'h0000_0000);
    bus(1'b1, `PCM_REG_CTRL, 32'h0000_0001, q);
    u_host.send({8'h0F, 8'hFE, `PCM_CMD_UPD_MAIN});
    u_host.proc(n);
    readOut(`PCM_CMD_READ_MAIN, 8'hFE, 16, q);
    check("locked", {24'h0, q[7:0]}, 32'h0000_00FF);
    foreach (unlock[i]) begin
      u_host.send(unlock[i]);
      u_host.proc(n);
    end
    readOut(`PCM_CMD_READ_SEC, 8'h00, 32, q);
    check("security", q, 32'hFFFF_FF07);
    bus(1'b0, `PCM_REG_STATUS, 32'h0000_0000, q);
    check("status", q, 32'h0000_0778);
    u_host.send({8'h0F, 8'hFE, `PCM_CMD_UPD_MAIN});
    u_host.proc(n);
    readOut(`PCM_CMD_READ_MAIN, 8'hFE, 16, q);
    check("unlocked", {24'h0, q[7:0]}, 32'h0000_000F);
    wrapUp();
  end
endmodule
bind pcm_card_memory pcm_monitor #(.PROG_CYCLES(PROG_CYCLES), .CODE_INIT(CODE_INIT)) u_mon (
  .mclk(mclk), .srst(srst), .cardClk(cardClk), .cardRst(cardRst), .cardIoIn(cardIoIn),
  .cardIoOut(cardIoOut), .cardIoOe(cardIoOe), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
  .avsWaitrequest(avsWaitrequest));
`default_nettype wire
